// file: inc/dsti_cfg.svh
// Purpose: constants of the serial target interface
// Assumes: core clock 10 MHz
// Notes: counts derive from times
`ifndef DSTI_CFG_SVH
`define DSTI_CFG_SVH
// timing
`define DSTI_CLK_PERIOD_NS 100
`define DSTI_LINK_PERIOD_NS 800
`define DSTI_HALF_CYC (`DSTI_LINK_PERIOD_NS / `DSTI_CLK_PERIOD_NS / 2)
`define DSTI_FILT 2
// spi frame
`define DSTI_SPI_BITS 5'd24
// i2c address and general call
`define DSTI_ADDR_HI 4'h9
`define DSTI_GC_ADDR 8'h00
`define DSTI_GC_RESET 8'h06
// strap codes
`define DSTI_STRAP_GND 3'h0
`define DSTI_STRAP_VDD 3'h1
`define DSTI_STRAP_SDA 3'h2
`define DSTI_STRAP_SCL 3'h3
// byte positions after the address
`define DSTI_IDX_CMD 2'h0
`define DSTI_IDX_UPPER 2'h1
`define DSTI_IDX_LOWER 2'h2
`endif

// file: inc/dsti_pkg.sv
// Purpose: types of the serial target interface
// Assumes: nothing
// Notes: constants live in dsti_cfg.svh
package dsti_pkg;
	// device i2c states
	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_RX, I_DACK,
		I_TX, I_TXACK, I_SKIP} dsti_ist_t;
	// host states
	typedef enum logic [3:0] {H_IDLE, H_START, H_LOW, H_SET, H_HIGH,
		H_STOP1, H_STOP2, H_STOP3, P_SEL, P_HIGH, P_LOW,
		P_END} dsti_hst_t;
	// host operations
	typedef enum logic [1:0] {OP_SPI_WR, OP_I2C_WR, OP_I2C_RD,
		OP_I2C_GC} dsti_op_t;
endpackage

// file: inc/dsti_if.sv
// Purpose: pins between host and device
// Assumes: bench sets strap_tie
// Notes: open-drain wires resolved here
`timescale 1ns/100ps
`default_nettype none
interface dsti_if;
	// host drives
	logic h_scl_out, h_scl_oe, h_sda_out, h_sda_oe;
	logic cs_n, sclk, serial_in;
	// device drives
	logic d_sda_out, d_sda_oe;
	// strap tie: 0 gnd, 1 vdd, 2 sda, 3 scl
	logic [1:0] strap_tie;
	// resolved wires
	logic scl, sda, addr_strap;
	assign scl = !(h_scl_oe && !h_scl_out);
	assign sda = !((h_sda_oe && !h_sda_out) || (d_sda_oe && !d_sda_out));
	assign addr_strap = strap_tie == 2'h0 ? 1'b0 :
		strap_tie == 2'h1 ? 1'b1 : strap_tie == 2'h2 ? sda : scl;
	modport device (input scl, sda, cs_n, sclk, serial_in, addr_strap,
		output d_sda_out, d_sda_oe);
	modport host (input sda, output h_scl_out, h_scl_oe, h_sda_out,
		h_sda_oe, cs_n, sclk, serial_in);
endinterface
`default_nettype wire

// file: verilog/dsti_sync.sv
// Purpose: two-flop synchroniser with glitch filter
// Assumes: inputs asynchronous to core_clk
// Notes: output moves after FILT equal samples
`timescale 1ns/100ps
`default_nettype none
module dsti_sync #(
	parameter int W = 1,
	parameter int FILT = 2
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// pins and filtered levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1; // first stage, read only by s2
	logic [W-1:0] s2; // second stage
	////////////////////////////////////////////////////////////////
	// synchroniser, free running
	always_ff @(posedge core_clk) begin
		s1 <= din;
		s2 <= s1;
	end
	////////////////////////////////////////////////////////////////
	// per-bit filter
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_f
			logic [3:0] cnt; // samples disagreeing with dout
			// take new level after FILT samples
			always_ff @(posedge core_clk) begin
				if (srst) begin
					dout[i] <= s2[i];
					cnt <= 4'h0;
				end else if (s2[i] == dout[i]) begin
					cnt <= 4'h0;
				end else if (cnt == 4'(FILT - 1)) begin
					dout[i] <= s2[i];
					cnt <= 4'h0;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// file: verilog/dsti_device.sv
// Purpose: device end: i2c target or 3-wire spi receiver
// Assumes: register file outside; rd_data follows rd_cmd
// Notes: mode caught once after reset release
`timescale 1ns/100ps
`default_nettype none
`include "dsti_cfg.svh"
module dsti_device
	import dsti_pkg::*;
#(
	parameter int FILT = `DSTI_FILT
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// pins
	dsti_if.device bus,
	input wire logic iface_select,
	// register side
	input wire logic [15:0] rd_data,
	output logic [7:0] rd_cmd,
	output logic wr_stb,
	output logic [7:0] wr_cmd,
	output logic [15:0] wr_data,
	output logic soft_reset,
	output logic i2c_mode
);
	import dsti_pkg::*;
	////////////////////////////////////////////////////////////////
	// synchronised pins
	logic f_scl, f_sda, f_cs_n, f_sclk, f_sdi, f_strap, f_sel;
	logic p_scl, p_sda, p_cs_n, p_sclk; // previous levels
	logic mode_taken; // mode latched once
	// glitch filter on every pin
	dsti_sync #(.W(7), .FILT(FILT)) u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.din({bus.scl, bus.sda, bus.cs_n, bus.sclk, bus.serial_in,
			bus.addr_strap, iface_select}),
		.dout({f_scl, f_sda, f_cs_n, f_sclk, f_sdi, f_strap, f_sel})
	);
	// edge history
	always_ff @(posedge core_clk) begin
		p_scl <= f_scl;
		p_sda <= f_sda;
		p_cs_n <= f_cs_n;
		p_sclk <= f_sclk;
	end
	// edge and condition decode
	wire spi_on = mode_taken && !i2c_mode;
	wire i2c_on = mode_taken && i2c_mode;
	wire scl_rise = f_scl && !p_scl;
	wire scl_fall = !f_scl && p_scl;
	wire start_c = i2c_on && f_scl && p_scl && p_sda && !f_sda;
	wire stop_c = i2c_on && f_scl && p_scl && !p_sda && f_sda;
	wire cs_fall = spi_on && p_cs_n && !f_cs_n;
	wire cs_rise = spi_on && !p_cs_n && f_cs_n;
	wire sclk_fall = spi_on && !f_cs_n && p_sclk && !f_sclk;
	////////////////////////////////////////////////////////////////
	// mode strap, taken once after release
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mode_taken <= 1'b0;
			i2c_mode <= 1'b0;
		end else if (!mode_taken) begin
			mode_taken <= 1'b1;
			i2c_mode <= f_sel;
		end
	end
	////////////////////////////////////////////////////////////////
	// spi receiver
	logic [23:0] spi_sr; // input shift register
	logic [4:0] spi_cnt; // falling edges, saturating
	wire spi_upd = cs_rise && spi_cnt >= `DSTI_SPI_BITS;
	// shift on sclk falls while selected
	always_ff @(posedge core_clk) begin
		if (srst || cs_fall || cs_rise) begin
			spi_cnt <= 5'h00;
			spi_sr <= 24'h000000;
		end else if (sclk_fall) begin
			spi_sr <= {spi_sr[22:0], f_sdi};
			if (spi_cnt < `DSTI_SPI_BITS)
				spi_cnt <= spi_cnt + 5'h01;
		end
	end
	////////////////////////////////////////////////////////////////
	// i2c target
	dsti_ist_t st; // target state
	logic [3:0] bitcnt; // bits in current byte
	logic [7:0] rx; // receive shift
	logic [7:0] tx; // transmit shift
	logic [1:0] byte_idx; // position after address
	logic rw; // controller reads
	logic is_gc; // general call frame
	logic tx_lower; // next byte sent is lower
	logic [7:0] upper; // upper data byte
	logic [2:0] strap_lat; // address bits for frame
	logic st_lo, st_hi, st_sda; // strap observations
	// strap code from observations during address byte
	wire [2:0] strap_now = st_lo ? `DSTI_STRAP_GND :
		st_hi ? `DSTI_STRAP_VDD :
		st_sda ? `DSTI_STRAP_SDA : `DSTI_STRAP_SCL;
	// own 7-bit address only; 10-bit prefix never matches
	wire addr_match = rx[7:4] == `DSTI_ADDR_HI &&
		rx[3:1] == strap_now;
	wire gc_match = rx == `DSTI_GC_ADDR;
	// ack decision at end of a received byte
	wire ack_ok = st == I_ADDR ? (addr_match || gc_match) :
		(!is_gc || (byte_idx == `DSTI_IDX_CMD &&
		rx == `DSTI_GC_RESET));
	wire byte_end = scl_fall && bitcnt == 4'h8;
	wire i2c_upd = st == I_DACK && scl_fall && !is_gc &&
		byte_idx == `DSTI_IDX_LOWER;
	wire gc_fire = st == I_DACK && scl_fall && is_gc;
	// strap watch over the address byte
	always_ff @(posedge core_clk) begin
		if (srst || start_c) begin
			st_lo <= 1'b1;
			st_hi <= 1'b1;
			st_sda <= 1'b1;
		end else if (st == I_ADDR) begin
			st_lo <= st_lo && !f_strap;
			st_hi <= st_hi && f_strap;
			st_sda <= st_sda && f_strap == f_sda;
		end
	end
	// target sequencer
	always_ff @(posedge core_clk) begin
		if (srst || !i2c_on || stop_c) begin
			st <= I_IDLE;
			bus.d_sda_oe <= 1'b0;
		end else if (start_c) begin
			st <= I_ADDR;
			bus.d_sda_oe <= 1'b0;
			bitcnt <= 4'h0;
			byte_idx <= `DSTI_IDX_CMD;
		end else begin
			unique case (st)
			I_IDLE, I_SKIP: begin
			end
			I_ADDR, I_RX: begin
				if (scl_rise) begin
					rx <= {rx[6:0], f_sda};
					bitcnt <= bitcnt + 4'h1;
				end else if (byte_end) begin
					bitcnt <= 4'h0;
					bus.d_sda_oe <= ack_ok;
					if (st == I_ADDR) begin
						rw <= rx[0];
						is_gc <= gc_match;
						strap_lat <= strap_now;
					end
					st <= !ack_ok ? I_SKIP :
						st == I_ADDR ? I_AACK : I_DACK;
				end
			end
			I_AACK: begin
				if (scl_fall) begin
					tx <= rd_data[15:8];
					tx_lower <= 1'b1;
					// first bit set while clock low
					bus.d_sda_oe <= rw && !rd_data[15];
					st <= rw ? I_TX : I_RX;
				end
			end
			I_DACK: begin
				if (scl_fall) begin
					bus.d_sda_oe <= 1'b0;
					st <= I_RX;
					// general call bytes never name a register
					if (byte_idx == `DSTI_IDX_CMD && !is_gc)
						rd_cmd <= rx;
					if (byte_idx == `DSTI_IDX_UPPER)
						upper <= rx;
					// further pairs repeat on the same command
					byte_idx <= byte_idx == `DSTI_IDX_LOWER ?
						`DSTI_IDX_UPPER : byte_idx + 2'h1;
				end
			end
			I_TX: begin
				if (scl_rise) begin
					bitcnt <= bitcnt + 4'h1;
				end else if (byte_end) begin
					bitcnt <= 4'h0;
					bus.d_sda_oe <= 1'b0;
					st <= I_TXACK;
				end else if (scl_fall) begin
					tx <= {tx[6:0], 1'b0};
					bus.d_sda_oe <= !tx[6];
				end
			end
			I_TXACK: begin
				if (scl_rise && f_sda) begin
					st <= I_SKIP; // controller nack ends read
				end else if (scl_fall) begin
					tx <= tx_lower ? rd_data[7:0] : rd_data[15:8];
					bus.d_sda_oe <= tx_lower ? !rd_data[7] :
						!rd_data[15];
					tx_lower <= !tx_lower;
					st <= I_TX;
				end
			end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// register side outputs, set wins over idle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_stb <= 1'b0;
			soft_reset <= 1'b0;
			wr_cmd <= 8'h00;
			wr_data <= 16'h0000;
			bus.d_sda_out <= 1'b0;
		end else begin
			wr_stb <= i2c_upd || spi_upd;
			soft_reset <= gc_fire;
			if (i2c_upd) begin
				wr_cmd <= rd_cmd;
				wr_data <= {upper, rx};
			end else if (spi_upd) begin
				wr_cmd <= spi_sr[23:16];
				wr_data <= spi_sr[15:0];
			end
		end
	end
endmodule
`default_nettype wire

// file: verilog/dsti_host.sv
// Purpose: controller end: drives i2c or spi frames
// Assumes: no clock stretching by the target
// Notes: link clock made by divider of core_clk
`timescale 1ns/100ps
`default_nettype none
`include "dsti_cfg.svh"
module dsti_host
	import dsti_pkg::*;
#(
	parameter int HALF = `DSTI_HALF_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// pins
	dsti_if.host bus,
	// request
	input wire logic req,
	input wire dsti_pkg::dsti_op_t op,
	input wire logic [2:0] tgt_low,
	input wire logic [7:0] cmd,
	input wire logic [15:0] wdata,
	input wire logic [4:0] spi_len,
	// answer
	output logic busy,
	output logic done,
	output logic nack,
	output logic [15:0] rd_data
);
	import dsti_pkg::*;
	dsti_hst_t st; // host state
	dsti_op_t op_q; // latched operation
	logic [7:0] tick_cnt; // half-period divider
	logic [4:0] bitn; // bit in byte or spi bit
	logic [1:0] byte_n; // byte in frame
	logic [7:0] sh; // i2c byte shift
	logic [23:0] ssh; // spi shift
	logic [2:0] low_q; // target address bits
	logic [7:0] cmd_q; // command byte
	logic [15:0] wd_q; // data bytes
	logic [4:0] len_q; // spi falls to send
	logic sda_in; // sda, two flops
	logic sda_s1; // first stage
	// byte for a frame position
	function automatic logic [7:0] byte_at(input logic [1:0] n);
		unique case (op_q)
		OP_I2C_GC: byte_at = n == 2'h0 ? `DSTI_GC_ADDR : `DSTI_GC_RESET;
		OP_I2C_RD: byte_at = n == 2'h0 ? {`DSTI_ADDR_HI, low_q, 1'b1} :
			8'hFF;
		default: byte_at = n == 2'h0 ? {`DSTI_ADDR_HI, low_q, 1'b0} :
			n == 2'h1 ? cmd_q : n == 2'h2 ? wd_q[15:8] : wd_q[7:0];
		endcase
	endfunction
	// frame shape
	wire tick = tick_cnt == 8'(HALF - 1);
	wire is_rx = op_q == OP_I2C_RD && byte_n != 2'h0;
	wire [1:0] last_b = op_q == OP_I2C_WR ? 2'h3 :
		op_q == OP_I2C_RD ? 2'h2 : 2'h1;
	////////////////////////////////////////////////////////////////
	// sda input synchroniser
	always_ff @(posedge core_clk) begin
		sda_s1 <= bus.sda;
		sda_in <= sda_s1;
	end
	// half-period divider
	always_ff @(posedge core_clk) begin
		// a refused request while busy must not disturb the bit timing
		if (srst || (req && !busy) || tick)
			tick_cnt <= 8'h00;
		else
			tick_cnt <= tick_cnt + 8'h01;
	end
	////////////////////////////////////////////////////////////////
	// frame sequencer
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= H_IDLE;
			busy <= 1'b0;
			done <= 1'b0;
			nack <= 1'b0;
			rd_data <= 16'h0000;
			bus.h_scl_oe <= 1'b0;
			bus.h_scl_out <= 1'b0;
			bus.h_sda_oe <= 1'b0;
			bus.h_sda_out <= 1'b0;
			bus.cs_n <= 1'b1;
			bus.sclk <= 1'b0;
			bus.serial_in <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (st)
			H_IDLE: begin
				if (req) begin
					op_q <= op;
					low_q <= tgt_low;
					cmd_q <= cmd;
					wd_q <= wdata;
					len_q <= spi_len;
					ssh <= {cmd, wdata};
					busy <= 1'b1;
					nack <= 1'b0;
					bitn <= 5'h00;
					byte_n <= 2'h0;
					if (op == OP_SPI_WR) begin
						bus.cs_n <= 1'b0;
						st <= P_SEL;
					end else begin
						bus.h_sda_oe <= 1'b1; // start
						st <= H_START;
					end
				end
			end
			H_START: if (tick) begin
				bus.h_scl_oe <= 1'b1;
				sh <= byte_at(2'h0); // address
				st <= H_LOW;
			end
			H_LOW: if (tick) begin
				// data moves only while clock low
				if (bitn != 5'h08)
					bus.h_sda_oe <= !is_rx && !sh[7];
				else
					bus.h_sda_oe <= is_rx && byte_n != last_b;
				st <= H_SET;
			end
			H_SET: if (tick) begin
				bus.h_scl_oe <= 1'b0;
				st <= H_HIGH;
			end
			H_HIGH: if (tick) begin
				bus.h_scl_oe <= 1'b1;
				st <= H_LOW;
				if (bitn != 5'h08) begin
					sh <= {sh[6:0], sda_in};
					bitn <= bitn + 5'h01;
				end else begin
					if (!is_rx && sda_in)
						nack <= 1'b1;
					if (is_rx && byte_n == 2'h1)
						rd_data[15:8] <= sh;
					if (is_rx && byte_n == 2'h2)
						rd_data[7:0] <= sh;
					bitn <= 5'h00;
					byte_n <= byte_n + 2'h1;
					sh <= byte_at(byte_n + 2'h1);
					if (byte_n == last_b || (!is_rx && sda_in))
						st <= H_STOP1;
				end
			end
			H_STOP1: if (tick) begin
				bus.h_sda_oe <= 1'b1;
				st <= H_STOP2;
			end
			H_STOP2: if (tick) begin
				bus.h_scl_oe <= 1'b0;
				st <= H_STOP3;
			end
			H_STOP3: if (tick) begin
				bus.h_sda_oe <= 1'b0; // stop
				busy <= 1'b0;
				done <= 1'b1;
				st <= H_IDLE;
			end
			P_SEL, P_LOW: if (tick) begin
				if (len_q == 5'h00) begin
					st <= P_END;
				end else begin
					bus.sclk <= 1'b1;
					bus.serial_in <= ssh[23];
					st <= P_HIGH;
				end
			end
			P_HIGH: if (tick) begin
				bus.sclk <= 1'b0;
				ssh <= {ssh[22:0], 1'b0};
				bitn <= bitn + 5'h01;
				st <= bitn + 5'h01 == len_q ? P_END : P_LOW;
			end
			P_END: if (tick) begin
				bus.cs_n <= 1'b1;
				busy <= 1'b0;
				done <= 1'b1;
				st <= H_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: tb/dsti_asserts.sv
// Purpose: wire checks between host end and device end
// Assumes: one core_clk domain; host half period of 4 cycles
// Notes: instantiated beside the interface, no bind
`timescale 1ns/100ps
`default_nettype none
module dsti_asserts (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// i2c wires
	input wire logic scl,
	input wire logic sda,
	input wire logic d_sda_oe,
	// spi wires
	input wire logic cs_n,
	input wire logic sclk
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////
	logic scl_q; // scl one cycle ago
	logic sda_q; // sda one cycle ago
	logic [5:0] cnt; // scl rises since start
	logic rw; // direction bit of this frame
	wire logic rise = scl && !scl_q; // scl rise seen
	wire logic start = scl && scl_q && sda_q && !sda; // start seen
	wire logic stop = scl && scl_q && !sda_q && sda; // stop seen
	// frame bit counter and direction capture
	always_ff @(posedge core_clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (srst || start) begin
			cnt <= 6'h00;
		end else if (rise) begin
			cnt <= cnt + 6'h01;
		end
		if (rise && cnt == 6'h07) begin
			rw <= sda;
		end
	end
	////////////////////////////////////////////////////////////////////
	// device stays off the bus for 8 core_clk cycles
	sequence s_quiet;
		!d_sda_oe [*8];
	endsequence
	property p_oe_low_scl;
		$changed(d_sda_oe) |-> !scl;
	endproperty
	a_oe_low_scl: assert property (p_oe_low_scl)
		else $error("device sda moved while scl high");
	// high period is 4 cycles with the default divider
	property p_ack_hold;
		rise && d_sda_oe |-> d_sda_oe [*4];
	endproperty
	a_ack_hold: assert property (p_ack_hold)
		else $error("device sda not held over scl high");
	property p_drive_min;
		$rose(d_sda_oe) |-> d_sda_oe [*8];
	endproperty
	a_drive_min: assert property (p_drive_min)
		else $error("device sda pull too short");
	property p_start_quiet;
		start |-> s_quiet;
	endproperty
	a_start_quiet: assert property (p_start_quiet)
		else $error("device drove sda during address");
	property p_stop_quiet;
		stop |-> s_quiet;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("device drove sda after stop");
	property p_sclk_idle;
		cs_n |-> !sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("sclk high outside spi frame");
	property p_spi_quiet;
		!cs_n |-> !d_sda_oe;
	endproperty
	a_spi_quiet: assert property (p_spi_quiet)
		else $error("device drove sda in spi frame");
	// whole nine-bit groups, plus the scl rise that opens the stop
	property p_nine;
		stop |-> cnt >= 6'h0A && (cnt % 6'h09) == 6'h01;
	endproperty
	a_nine: assert property (p_nine)
		else $error("frame not whole nine-bit groups");
	property p_ack_slot;
		rise && d_sda_oe |->
			((cnt % 6'h09) == 6'h08) == (!rw || cnt == 6'h08);
	endproperty
	a_ack_slot: assert property (p_ack_slot)
		else $error("device sda pull in wrong clock slot");
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench, host and device face to face
// Assumes: host half period 4 cycles, filter 2
// Notes: table rows are i2c cases; spi mode after a second reset
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import dsti_pkg::*;
	// one case: request, then pulses and nack expected
	typedef struct packed {
		dsti_op_t op;
		logic [1:0] tie;
		logic [2:0] tgt;
		logic [7:0] cmd;
		logic [15:0] wd;
		logic stb;
		logic nk;
		logic sr;
	} dsti_row_t;
	logic core_clk = 1'b0; // 10 MHz
	logic srst = 1'b1; // sync reset
	logic iface_select = 1'b1; // high picks i2c
	logic req = 1'b0;
	dsti_op_t op = OP_I2C_WR;
	logic [2:0] tgt_low = 3'h0;
	logic [7:0] cmd = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic [4:0] spi_len = 5'h00;
	logic [15:0] rd_data = 16'h0000; // register content seen by device
	logic [7:0] rd_cmd, wr_cmd, last_cmd;
	logic [15:0] wr_data, h_rd;
	logic wr_stb, soft_reset, i2c_mode, busy, done, nack;
	int err_count = 0;
	int comparisons = 0;
	int n_stb, n_sr, n_rise, n_fall; // pulse and edge counts
	logic [63:0] i2c_bits, spi_bits; // bit logs off the wires
	logic [35:0] exp_bits;
	dsti_row_t r;
	dsti_row_t rows [12] = '{
		'{OP_I2C_WR, 2'h0, 3'h0, 8'h00, 16'h1234, 1'h1, 1'h0, 1'h0},
		'{OP_I2C_WR, 2'h1, 3'h1, 8'h01, 16'hABCD, 1'h1, 1'h0, 1'h0},
		'{OP_I2C_WR, 2'h2, 3'h2, 8'h02, 16'h00FF, 1'h1, 1'h0, 1'h0},
		'{OP_I2C_WR, 2'h3, 3'h3, 8'h03, 16'h8001, 1'h1, 1'h0, 1'h0},
		'{OP_I2C_WR, 2'h0, 3'h0, 8'h04, 16'hFFFF, 1'h1, 1'h0, 1'h0},
		'{OP_I2C_WR, 2'h1, 3'h1, 8'h05, 16'h5A5A, 1'h1, 1'h0, 1'h0},
		'{OP_I2C_WR, 2'h2, 3'h2, 8'h07, 16'h0F0F, 1'h1, 1'h0, 1'h0},
		'{OP_I2C_WR, 2'h3, 3'h3, 8'h08, 16'hC3C3, 1'h1, 1'h0, 1'h0},
		'{OP_I2C_WR, 2'h0, 3'h1, 8'h01, 16'h1111, 1'h0, 1'h1, 1'h0},
		'{OP_I2C_RD, 2'h0, 3'h0, 8'h00, 16'h0000, 1'h0, 1'h0, 1'h0},
		'{OP_I2C_GC, 2'h0, 3'h0, 8'h00, 16'h0000, 1'h0, 1'h0, 1'h1},
		'{OP_I2C_WR, 2'h3, 3'h0, 8'h02, 16'h2222, 1'h0, 1'h1, 1'h0}
	};
	////////////////////////////////////////////////////////////////////
	dsti_if dsti_if_i ();
	dsti_host dsti_host_i (.core_clk(core_clk), .srst(srst),
		.bus(dsti_if_i), .req(req), .op(op), .tgt_low(tgt_low),
		.cmd(cmd), .wdata(wdata), .spi_len(spi_len), .busy(busy),
		.done(done), .nack(nack), .rd_data(h_rd));
	dsti_device dsti_device_i (.core_clk(core_clk), .srst(srst),
		.bus(dsti_if_i), .iface_select(iface_select),
		.rd_data(rd_data), .rd_cmd(rd_cmd), .wr_stb(wr_stb),
		.wr_cmd(wr_cmd), .wr_data(wr_data), .soft_reset(soft_reset),
		.i2c_mode(i2c_mode));
	dsti_asserts dsti_asserts_i (.core_clk(core_clk), .srst(srst),
		.scl(dsti_if_i.scl), .sda(dsti_if_i.sda),
		.d_sda_oe(dsti_if_i.d_sda_oe), .cs_n(dsti_if_i.cs_n),
		.sclk(dsti_if_i.sclk));
	////////////////////////////////////////////////////////////////////
	// clock and register content answering the command
	initial begin
		dsti_if_i.strap_tie = 2'h0;
		forever #50 core_clk = !core_clk;
	end
	always @(posedge core_clk) begin
		rd_data <= {rd_cmd, ~rd_cmd};
	end
	// bit logs: i2c at scl rise, spi at sclk fall
	always @(posedge dsti_if_i.scl) begin
		n_rise++;
		i2c_bits = {i2c_bits[62:0], dsti_if_i.sda};
	end
	always @(negedge dsti_if_i.sclk) begin
		n_fall++;
		spi_bits = {spi_bits[62:0], dsti_if_i.serial_in};
	end
	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task samp();
		@(negedge core_clk);
		n_stb += wr_stb;
		n_sr += soft_reset;
	endtask
	// reset 5 cycles, idle values, then mode taken from select pin
	task do_reset();
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		chk({wr_stb, soft_reset, i2c_mode, busy, done, nack,
			dsti_if_i.d_sda_oe, dsti_if_i.cs_n}, 8'h01);
		@(posedge core_clk);
		srst <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk(i2c_mode, iface_select);
	endtask
	// one request; pulses counted until done and a short settle
	task xfer(input dsti_op_t o, input logic [1:0] tie,
		input logic [2:0] t, input logic [7:0] c, input logic [15:0] w,
		input logic [4:0] n);
		int k;
		@(posedge core_clk);
		req <= 1'b1;
		op <= o;
		dsti_if_i.strap_tie <= tie;
		tgt_low <= t;
		cmd <= c;
		wdata <= w;
		spi_len <= n;
		n_stb = 0;
		n_sr = 0;
		n_rise = 0;
		n_fall = 0;
		@(posedge core_clk);
		req <= 1'b0;
		for (k = 0; k < 1000 && done !== 1'b1; k++) samp();
		chk(done, 1'h1);
		repeat (16) samp();
	endtask
	task test_done();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// watchdog: table takes about 4700 cycles, spi part far less
	initial begin
		repeat (30000) @(posedge core_clk);
		err_count++;
		test_done();
	end
	initial begin
		do_reset();
		foreach (rows[i]) begin
			r = rows[i];
			xfer(r.op, r.tie, r.tgt, r.cmd, r.wd, 5'h00);
			chk(n_stb, r.stb);
			chk(n_sr, r.sr);
			chk(nack, r.nk);
			if (r.stb) begin
				last_cmd = r.cmd;
				exp_bits = {4'h9, r.tgt, 2'h0, r.cmd, 1'h0, r.wd[15:8],
					1'h0, r.wd[7:0], 1'h0};
				chk({wr_cmd, wr_data}, {r.cmd, r.wd});
				// 36 bit clocks, then the scl rise that opens the stop
				chk(n_rise, 37);
				chk(i2c_bits[36:1], exp_bits);
			end
			if (r.op == OP_I2C_RD) begin
				chk(h_rd, {last_cmd, ~last_cmd});
			end
		end
		// spi mode needs a fresh reset with the select pin low
		@(posedge core_clk);
		iface_select <= 1'b0;
		do_reset();
		xfer(OP_SPI_WR, 2'h0, 3'h0, 8'h08, 16'hA55A, 5'h18);
		chk(n_stb, 1);
		chk(n_fall, 24);
		chk({wr_cmd, wr_data, spi_bits[23:0]}, 48'h08A55A08A55A);
		// select rises after 23 falls: frame dropped
		xfer(OP_SPI_WR, 2'h0, 3'h0, 8'h04, 16'h1111, 5'h17);
		chk(n_stb, 0);
		chk({wr_cmd, wr_data}, 24'h08A55A);
		// select pulse with no clock at all: nothing shifts, nothing lands
		xfer(OP_SPI_WR, 2'h0, 3'h0, 8'h07, 16'h3333, 5'h00);
		chk({n_stb[0], n_fall[4:0]}, 6'h00);
		chk({wr_cmd, wr_data}, 24'h08A55A);
		xfer(OP_SPI_WR, 2'h0, 3'h0, 8'h05, 16'h2222, 5'h18);
		chk({n_stb[0], wr_cmd, wr_data}, 25'h1052222);
		// i2c traffic is ignored in spi mode
		xfer(OP_I2C_WR, 2'h0, 3'h0, 8'h08, 16'h3333, 5'h00);
		chk({n_stb[0], nack}, 2'h1);
		test_done();
	end
endmodule
`default_nettype wire
